// file: verilog/hsc_defs.svh
// Constants for the high-speed counter: modes, status codes, widths, timing.
`ifndef HSC_DEFS_SVH
`define HSC_DEFS_SVH
`define HSC_CNT_W 32
`define HSC_OUT_W 4
`define HSC_IN_W 12
`define HSC_GRP_W 3
`define HSC_MODE_W 4
`define HSC_MODE_MAX 4'h9
`define HSC_GRP_MAX 3'h5
`define HSC_STS_W 8
`define HSC_STS_IDLE 8'h00
`define HSC_STS_RUN 8'h01
`define HSC_STS_BADCFG 8'h04
`define HSC_FILT_W 8
`define HSC_FILT_RST 8'h02
`endif

// file: verilog/hsc_pkg.sv
// Types for the high-speed counter: configuration record and status record.
package hsc_pkg;
    `include "hsc_defs.svh"
    // Configuration record from the controlling party
    typedef struct packed {
        logic preset_schedule_enable;
        logic [`HSC_GRP_W-1:0] input_group_select;
        logic [`HSC_MODE_W-1:0] count_mode;
        logic signed [`HSC_CNT_W-1:0] high_preset_value;
        logic signed [`HSC_CNT_W-1:0] low_preset_value;
        logic signed [`HSC_CNT_W-1:0] overflow_limit;
        logic signed [`HSC_CNT_W-1:0] underflow_limit;
        logic [`HSC_OUT_W-1:0] output_enable_mask;
        logic [`HSC_OUT_W-1:0] high_preset_output_pattern;
        logic [`HSC_OUT_W-1:0] low_preset_output_pattern;
    } counter_config_record_s;
    // Count status reported back
    typedef struct packed {
        logic signed [`HSC_CNT_W-1:0] accumulator;
        logic high_preset_reached;
        logic low_preset_reached;
        logic overflow;
        logic underflow;
        logic count_up;
    } counter_status_record_s;
endpackage

// file: verilog/hsc_counter.sv
// High-speed counter with presets, limits and masked output control.
`timescale 1ns/1ps
`include "hsc_defs.svh"
module hsc_counter #(
    parameter int FILT_W = `HSC_FILT_W
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic counter_enable,
    input wire hsc_pkg::counter_config_record_s counter_config_record,
    input wire logic [FILT_W-1:0] filter_cycles,
    input wire logic group1_in_use,
    input wire logic [`HSC_IN_W-1:0] embedded_inputs,
    output logic [`HSC_OUT_W-1:0] embedded_outputs,
    output hsc_pkg::counter_status_record_s counter_status_record,
    output logic [`HSC_STS_W-1:0] status_code,
    output logic config_fault
);
    import hsc_pkg::*;

    // =============================================
    // Parameter check
    // Refused at elaboration, so a bad width never reaches a netlist
    if (FILT_W < 1 || FILT_W > 16) begin : g_bad_filt
        $error("hsc_counter: FILT_W out of range");
    end

    // =============================================
    // Input synchronisers and filters
    logic [`HSC_IN_W-1:0] sync1_r; // First stage, read only by second
    logic [`HSC_IN_W-1:0] sync2_r; // Second stage
    logic [`HSC_IN_W-1:0] filt_r; // Debounced level
    logic [`HSC_IN_W-1:0] filt_nxt;
    logic [`HSC_IN_W-1:0] prev_r; // Last filtered level, for edges
    logic [FILT_W-1:0] fcnt_r [`HSC_IN_W]; // Per-pin stability counters
    logic [FILT_W-1:0] fcnt_nxt [`HSC_IN_W];

    // Two-stage synchroniser for the asynchronous pins
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= embedded_inputs;
            sync2_r <= sync1_r;
        end
    end

    // A pin must hold a new level for filter_cycles + 1 cycles before it is accepted;
    // longer settings reject more bounce but cap the top count rate
    genvar gi;
    generate
        for (gi = 0; gi < `HSC_IN_W; gi++) begin : g_filt
            always_comb begin
                filt_nxt[gi] = filt_r[gi];
                fcnt_nxt[gi] = '0;
                if (sync2_r[gi] != filt_r[gi]) begin
                    if (fcnt_r[gi] >= filter_cycles) begin
                        filt_nxt[gi] = sync2_r[gi];
                    end else begin
                        fcnt_nxt[gi] = fcnt_r[gi] + 1'b1;
                    end
                end
            end
            always_ff @(posedge clk_sys or negedge reset_n) begin
                if (!reset_n) begin
                    filt_r[gi] <= 1'b0;
                    fcnt_r[gi] <= '0;
                end else begin
                    filt_r[gi] <= filt_nxt[gi];
                    fcnt_r[gi] <= fcnt_nxt[gi];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            prev_r <= '0;
        end else begin
            prev_r <= filt_r;
        end
    end

    // =============================================
    // Configuration check and input routing
    // Odd modes need a group that owns reset and hold pins
    function automatic logic cfg_valid(input counter_config_record_s c, input logic g1);
        logic ok;
        ok = (c.count_mode <= `HSC_MODE_MAX) && (c.input_group_select <= `HSC_GRP_MAX);
        if (c.count_mode[0] && !(c.input_group_select == 3'h0 ||
            c.input_group_select == 3'h2 || c.input_group_select == 3'h4)) begin
            ok = 1'b0;
        end
        if (c.input_group_select == 3'h0 && g1) begin
            ok = 1'b0;
        end
        if (c.preset_schedule_enable) begin
            ok = 1'b0;
        end
        if (!c.count_mode[3] && c.count_mode[2:1] == 2'b00) begin
            // Low preset plays no part in the up modes, not even in this check
            ok = ok && (c.high_preset_value > 0);
        end else begin
            ok = ok && (c.high_preset_value > c.low_preset_value) &&
                (c.underflow_limit <= c.low_preset_value);
        end
        return ok && (c.overflow_limit >= c.high_preset_value);
    endfunction

    counter_config_record_s cfg;
    assign cfg = counter_config_record;
    logic valid;
    assign valid = cfg_valid(cfg, group1_in_use);
    logic ch_a;
    logic ch_b;
    logic ext_rst;
    logic ext_hold;
    logic a_rise;
    logic a_edge;
    logic b_rise;
    logic b_edge;
    logic [3:0] base; // First pin of the selected group
    logic uses_ext;

    // Each group takes two pins; in odd modes groups 0/2/4 borrow the next pair as reset
    // and hold, which is why the pair's own group is then unusable
    always_comb begin
        base = {cfg.input_group_select, 1'b0};
        ch_a = filt_r[base];
        ch_b = filt_r[base + 4'h1];
        a_rise = filt_r[base] && !prev_r[base];
        a_edge = filt_r[base] ^ prev_r[base];
        b_rise = filt_r[base + 4'h1] && !prev_r[base + 4'h1];
        b_edge = filt_r[base + 4'h1] ^ prev_r[base + 4'h1];
        uses_ext = cfg.count_mode[0];
        ext_rst = uses_ext && filt_r[base + 4'h2];
        ext_hold = uses_ext && filt_r[base + 4'h3];
    end

    // =============================================
    // Count step per mode
    logic inc;
    logic dec;
    logic dir_up;
    always_comb begin
        inc = 1'b0;
        dec = 1'b0;
        unique case (cfg.count_mode[3:1])
            3'h0: inc = a_rise;
            3'h1: begin
                inc = a_rise && ch_b;
                dec = a_rise && !ch_b;
            end
            3'h2: begin
                inc = a_rise && !b_rise;
                dec = b_rise && !a_rise;
            end
            3'h3: begin
                inc = a_rise && !ch_b;
                dec = a_rise && ch_b;
            end
            3'h4: begin
                // x4: every single-phase edge, direction from phase relation
                inc = (a_edge && (ch_a != ch_b)) || (b_edge && (ch_a == ch_b));
                dec = (a_edge && (ch_a == ch_b)) || (b_edge && (ch_a != ch_b));
                if (a_edge && b_edge) begin
                    inc = 1'b0; // Both moved: lost step, drop it
                    dec = 1'b0;
                end
            end
            default: ;
        endcase
        dir_up = inc;
    end

    // =============================================
    // Accumulator, presets and outputs
    logic signed [`HSC_CNT_W-1:0] acc_r;
    logic signed [`HSC_CNT_W-1:0] acc_nxt;
    logic [`HSC_OUT_W-1:0] out_r;
    logic [`HSC_OUT_W-1:0] out_nxt;
    logic hp_r, hp_nxt, lp_r, lp_nxt, of_r, of_nxt, uf_r, uf_nxt, up_r, up_nxt;
    logic [`HSC_STS_W-1:0] sts_r;
    logic [`HSC_STS_W-1:0] sts_nxt;
    logic fault_r;
    logic fault_nxt;
    logic up_mode;
    assign up_mode = (cfg.count_mode[3:1] == 3'h0);

    always_comb begin
        acc_nxt = acc_r;
        out_nxt = out_r;
        hp_nxt = 1'b0;
        lp_nxt = 1'b0;
        of_nxt = of_r;
        uf_nxt = uf_r;
        up_nxt = up_r;
        fault_nxt = fault_r;
        sts_nxt = sts_r;
        if (!counter_enable) begin
            sts_nxt = `HSC_STS_IDLE;
            fault_nxt = 1'b0;
        end else if (!valid || fault_r) begin
            sts_nxt = `HSC_STS_BADCFG;
            fault_nxt = 1'b1; // Latched until enable drops
        end else begin
            sts_nxt = `HSC_STS_RUN;
            if (ext_rst) begin
                acc_nxt = '0;
                out_nxt = '0; // Reset drops preset outputs
                of_nxt = 1'b0;
                uf_nxt = 1'b0;
            end else if (!ext_hold && (inc || dec)) begin
                up_nxt = dir_up;
                acc_nxt = inc ? acc_r + 1 : acc_r - 1;
                if (acc_nxt > cfg.overflow_limit) begin
                    of_nxt = 1'b1;
                    acc_nxt = cfg.underflow_limit; // Wraps to the far limit
                end else if (acc_nxt < cfg.underflow_limit) begin
                    uf_nxt = 1'b1;
                    acc_nxt = cfg.overflow_limit;
                end
                if (inc && acc_nxt == cfg.high_preset_value) begin
                    hp_nxt = 1'b1;
                    // Only masked outputs are touched
                    out_nxt = (out_r & ~cfg.output_enable_mask) | (cfg.output_enable_mask &
                        (out_r | cfg.high_preset_output_pattern));
                    if (up_mode) begin
                        acc_nxt = '0;
                    end
                end else if (dec && !up_mode && acc_nxt == cfg.low_preset_value) begin
                    lp_nxt = 1'b1;
                    out_nxt = (out_r & ~(cfg.output_enable_mask & cfg.high_preset_output_pattern))
                        | (cfg.output_enable_mask & cfg.low_preset_output_pattern);
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            acc_r <= '0;
            out_r <= '0;
            hp_r <= 1'b0;
            lp_r <= 1'b0;
            of_r <= 1'b0;
            uf_r <= 1'b0;
            up_r <= 1'b0;
            sts_r <= `HSC_STS_IDLE;
            fault_r <= 1'b0;
        end else begin
            acc_r <= acc_nxt;
            out_r <= out_nxt;
            hp_r <= hp_nxt;
            lp_r <= lp_nxt;
            of_r <= of_nxt;
            uf_r <= uf_nxt;
            up_r <= up_nxt;
            sts_r <= sts_nxt;
            fault_r <= fault_nxt;
        end
    end

    assign embedded_outputs = out_r;
    assign counter_status_record = '{acc_r, hp_r, lp_r, of_r, uf_r, up_r};
    assign status_code = sts_r;
    assign config_fault = fault_r;

    // =============================================
    // Assertions
    up_clear_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        hp_r && $past(up_mode) |-> acc_r == 0) else $error("up mode did not clear");
    odd_group_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        counter_enable && cfg.count_mode[0] && cfg.input_group_select == 3'h1
        |=> status_code == `HSC_STS_BADCFG) else $error("odd mode accepted group 1");
    mask_gate_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        $stable(cfg.output_enable_mask) && !$past(ext_rst)
        |-> ((out_r ^ $past(out_r)) & ~cfg.output_enable_mask) == 0)
        else $error("unmasked output changed");
    hp_out_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        hp_r |-> (out_r & $past(cfg.output_enable_mask & cfg.high_preset_output_pattern))
        == $past(cfg.output_enable_mask & cfg.high_preset_output_pattern))
        else $error("high preset output missing");
    lp_out_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        lp_r |-> (out_r & $past(cfg.output_enable_mask & cfg.low_preset_output_pattern))
        == $past(cfg.output_enable_mask & cfg.low_preset_output_pattern))
        else $error("low preset output missing");
    run_sts_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        counter_enable && valid && !fault_r |=> status_code == `HSC_STS_RUN)
        else $error("run status missing");
    cfg_fault_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        counter_enable && !valid |=> config_fault ##1 (config_fault || !$past(counter_enable)))
        else $error("fault not raised");
    hold_count_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (!counter_enable || (ext_hold && !ext_rst)) |=> $stable(acc_r))
        else $error("count moved while held or disabled");
    no_lp_up_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        $past(up_mode) |-> !lp_r) else $error("low preset in up mode");
endmodule

// file: bench/enc_model.sv
// Pulse source model: encoder phases and switch levels on the counter pins.
`timescale 1ns/1ps
`include "hsc_defs.svh"
module enc_model #(
    parameter int HOLD = 10
) (
    input wire logic clk_sys,
    output logic [`HSC_IN_W-1:0] pins
);
    // =========================================
    // Pin drive
    // Encoder lines are driven at all times, so they idle low, never floating
    initial begin
        pins = '0;
    end
    // Each level is held well past the filter window, so every edge is real
    task automatic set(input int idx, input logic v);
        @(posedge clk_sys);
        pins[idx] <= v;
        repeat (HOLD) @(posedge clk_sys);
    endtask
    // One full pulse on a pin
    task automatic pulse(input int idx);
        set(idx, 1'b1);
        set(idx, 1'b0);
    endtask
    // Single-cycle spike, shorter than any filter setting used by the bench
    task automatic glitch(input int idx);
        @(posedge clk_sys);
        pins[idx] <= 1'b1;
        @(posedge clk_sys);
        pins[idx] <= 1'b0;
        repeat (HOLD) @(posedge clk_sys);
    endtask
endmodule

// file: bench/tb.sv
// Self-checking bench for the high-speed counter.
`timescale 1ns/1ps
`include "hsc_defs.svh"
module tb;
    import hsc_pkg::*;
    // =========================================
    // Signals
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic counter_enable = 1'b0;
    counter_config_record_s cfg = '0;
    logic [7:0] filter_cycles = 8'h02;
    logic group1_in_use = 1'b0;
    logic [`HSC_IN_W-1:0] pins;
    logic [`HSC_OUT_W-1:0] outs;
    counter_status_record_s sts;
    logic [`HSC_STS_W-1:0] status_code;
    logic config_fault;
    int failures = 0;
    int compares = 0;
    logic [31:0] lfsr = 32'ha10c;
    logic signed [31:0] exp_q[$]; // Expected accumulator values, oldest first
    logic signed [31:0] prev_acc = '0;
    always #2.5 clk_sys = ~clk_sys;
    enc_model i_src (.clk_sys(clk_sys), .pins(pins));
    hsc_counter i_dut (
        .clk_sys(clk_sys), .reset_n(reset_n), .counter_enable(counter_enable),
        .counter_config_record(cfg), .filter_cycles(filter_cycles),
        .group1_in_use(group1_in_use), .embedded_inputs(pins),
        .embedded_outputs(outs), .counter_status_record(sts),
        .status_code(status_code), .config_fault(config_fault)
    );
    // =========================================
    // Helpers
    // Next state of the bench's pseudo-random source
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask
    task automatic final_report();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Reset, load a record, enable; status and fault must match validity
    task automatic start(input logic [3:0] m, input logic [2:0] g, input int hp, input int lp,
                         input int ov, input int un, input logic good);
        @(posedge clk_sys);
        reset_n <= 1'b0;
        counter_enable <= 1'b0;
        cfg.preset_schedule_enable <= 1'b0;
        cfg.count_mode <= m;
        cfg.input_group_select <= g;
        cfg.high_preset_value <= hp;
        cfg.low_preset_value <= lp;
        cfg.overflow_limit <= ov;
        cfg.underflow_limit <= un;
        cfg.output_enable_mask <= 4'h3;
        cfg.high_preset_output_pattern <= 4'h5;
        cfg.low_preset_output_pattern <= 4'h6;
        repeat (2) @(posedge clk_sys);
        reset_n <= 1'b1;
        counter_enable <= 1'b1;
        repeat (3) @(posedge clk_sys);
        check(status_code, good ? 8'h01 : 8'h04, "status");
        check(config_fault, !good, "fault");
    endtask
    // Move a pin, noting the count it should produce
    task automatic mv(input int idx, input logic v, input bit push, input int e);
        if (push) exp_q.push_back(e);
        i_src.set(idx, v);
    endtask
    task automatic cnt(input int idx, input int e);
        exp_q.push_back(e);
        i_src.pulse(idx);
    endtask
    task automatic settle();
        repeat (12) @(posedge clk_sys);
        check(exp_q.size(), 0, "pending counts");
    endtask
    // =========================================
    // Monitor: out of reset, every accumulator change consumes the oldest expectation, or counts as unexpected when none is queued
    always @(posedge clk_sys) begin
        if (!reset_n) begin
            prev_acc <= '0;
        end else if (sts.accumulator !== prev_acc) begin
            prev_acc <= sts.accumulator;
            if (exp_q.size() == 0) check(32'h1, 32'h0, "unexpected count");
            else check(sts.accumulator, exp_q.pop_front(), "accumulator");
        end
    end
    // Watchdog against a hung scenario or stuck wait
    initial begin
        repeat (20000) @(posedge clk_sys);
        failures++;
        $display("mismatch at %0t: watchdog expired", $time);
        final_report();
    end
    // =========================================
    // Scenarios
    initial begin
        repeat (2) @(posedge clk_sys);
        reset_n <= 1'b1;
        lfsr = lfsr_next(lfsr);
        filter_cycles <= 8'h02 + {6'h00, lfsr[1:0]};
        // Up count; low preset above high preset is ignored here
        start(4'h0, 3'h0, 2, 5, 9, -9, 1'b1);
        i_src.glitch(0);
        cnt(0, 1);
        cnt(0, 0);
        settle();
        check(outs, 4'h1, "high preset outputs");
        counter_enable <= 1'b0;
        i_src.pulse(0);
        settle();
        check(status_code, 8'h00, "idle status");
        // Separate up and down pins, low then high preset, then overflow wrap
        start(4'h4, 3'h1, 3, -1, 3, -3, 1'b1);
        cnt(3, -1);
        settle();
        check(outs, 4'h2, "low preset outputs");
        for (int i = 0; i <= 3; i++) cnt(2, i);
        cnt(2, -3);
        settle();
        check(outs[0], 1'b1, "high preset output");
        check(sts.overflow, 1'b1, "overflow");
        // One step below the underflow limit wraps to the overflow limit
        cnt(3, 3);
        settle();
        check(sts.underflow, 1'b1, "underflow");
        check(sts.count_up, 1'b0, "direction down");
        // Direction input on the last group; a high direction level counts up
        start(4'h2, 3'h5, 5, -5, 9, -9, 1'b1);
        cnt(10, -1);
        mv(11, 1'b1, 0, 0);
        cnt(10, 0);
        mv(11, 1'b0, 0, 0);
        settle();
        check(sts.count_up, 1'b1, "direction up");
        // Quadrature x1: forward cycle then reverse cycle
        start(4'h6, 3'h0, 5, -5, 9, -9, 1'b1);
        mv(0, 1'b1, 1, 1);
        mv(1, 1'b1, 0, 0);
        mv(0, 1'b0, 0, 0);
        mv(1, 1'b0, 0, 0);
        mv(1, 1'b1, 0, 0);
        mv(0, 1'b1, 1, 0);
        mv(1, 1'b0, 0, 0);
        mv(0, 1'b0, 0, 0);
        settle();
        // Quadrature x4: every edge counts
        start(4'h8, 3'h2, 9, -9, 20, -20, 1'b1);
        mv(4, 1'b1, 1, 1);
        mv(5, 1'b1, 1, 2);
        mv(4, 1'b0, 1, 3);
        mv(5, 1'b0, 1, 4);
        mv(5, 1'b1, 1, 3);
        mv(4, 1'b1, 1, 2);
        // Back to both phases low, so no level is left high across the next reset
        mv(5, 1'b0, 1, 1);
        mv(4, 1'b0, 1, 0);
        settle();
        // Direction mode with hold and external reset on group 2
        start(4'h3, 3'h2, 5, -5, 9, -9, 1'b1);
        mv(5, 1'b1, 0, 0);
        cnt(4, 1);
        mv(7, 1'b1, 0, 0);
        i_src.pulse(4);
        mv(7, 1'b0, 0, 0);
        mv(6, 1'b1, 1, 0);
        mv(6, 1'b0, 0, 0);
        cnt(4, 1);
        mv(5, 1'b0, 0, 0);
        settle();
        // Refused records: odd mode on group 1, group 0 blocked, mode out of range
        start(4'h1, 3'h1, 5, -5, 9, -9, 1'b0);
        group1_in_use <= 1'b1;
        start(4'h0, 3'h0, 5, -5, 9, -9, 1'b0);
        group1_in_use <= 1'b0;
        start(4'ha, 3'h0, 5, -5, 9, -9, 1'b0);
        i_src.pulse(0);
        settle();
        final_report();
    end
endmodule
